// file: hw/msmp_port.v
// Behaviour
// - transmit enable spans first to last nibble
// - receive side timed by receive clock
// - transmit side timed by transmit clock
// - independent concurrent four-bit paths
// - only the slow line rate supported; link clocks must run well below sys_clk
// - device drives management clock
// - device starts management transfers
// - fifth bits, signal detect only symbol modes
// - symbol modes use five-bit symbols
`timescale 1ns/1ps
`default_nettype none
`include "msmp_defs.vh"

module msmp_port (
  // system
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [1:0]  mode,
  // phy receive pins
  input  wire        rx_clk,
  input  wire [3:0]  rx_data_in,
  input  wire        rx_sym4_in,
  input  wire        rx_valid_in,
  input  wire        rx_err_in,
  input  wire        crs_in,
  input  wire        col_in,
  input  wire        signal_detect_in,
  // phy transmit pins
  input  wire        tx_clk,
  output reg  [3:0]  tx_data_r,
  output reg         tx_sym4_r,
  output reg         tx_en_r,
  // user transmit stream
  input  wire        tx_valid,
  input  wire [4:0]  tx_sym,
  input  wire        tx_last,
  output wire        tx_ready,
  // user receive stream
  output reg  [4:0]  rx_sym_r,
  output reg         rx_sym_valid_r,
  output reg         rx_frame_end_r,
  output reg         rx_frame_err_r,
  output reg         rx_frame_err_flag_r,
  output wire [`MSMP_RXM_DW-1:0] rx_mem_data,
  input  wire [`MSMP_RXM_AW-1:0] rx_mem_addr,
  output reg  [`MSMP_RXM_AW-1:0] rx_mem_len_r,
  // status
  output reg         crs_r,
  output reg         col_r,
  output reg         link_ok_r,
  // management
  input  wire        mgmt_start,
  input  wire        mgmt_read,
  input  wire [4:0]  mgmt_phy,
  input  wire [4:0]  mgmt_reg,
  input  wire [15:0] mgmt_wdata,
  output wire        mgmt_busy,
  output reg  [15:0] mgmt_rdata_r,
  output reg         mgmt_done_r,
  output reg         mdc_r,
  output reg         mdio_o_r,
  output reg         mdio_oe_r,
  input  wire        mdio_i
);

  reg rst_s1_r, rst_s2_r;
  wire rst_sn = rst_s2_r;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // two-stage sync of every pin input; bit 0 rx_clk, 1 tx_clk, 2 dv, 3 err,
  // 4 crs, 5 col, 6 sd, 7 mdio, 8..11 rxd, 12 rxd4
  localparam NS = 13;
  wire [NS-1:0] pin_in = {rx_sym4_in, rx_data_in, mdio_i, signal_detect_in,
                          col_in, crs_in, rx_err_in, rx_valid_in, tx_clk, rx_clk};
  reg  [NS-1:0] s1_r, s2_r;
  reg  [1:0]    clk_d_r;
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or negedge rst_sn) begin
        if (!rst_sn) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate

  // data pins settle half a link period before the rising edge, so the synced
  // copies are stable when the synced clock edge appears
  wire sym_mode = mode[1];
  wire rx_rise  = s2_r[0] & ~clk_d_r[0];
  wire tx_fall  = ~s2_r[1] & clk_d_r[1];
  wire rx_dv_s  = s2_r[2];
  wire [4:0] rxd_s = {s2_r[12] & sym_mode, s2_r[11:8]};

  always @(posedge sys_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      clk_d_r   <= 2'h0;
      crs_r     <= 1'b0;
      col_r     <= 1'b0;
      link_ok_r <= 1'b0;
    end else begin
      clk_d_r   <= s2_r[1:0];
      crs_r     <= s2_r[4];
      col_r     <= s2_r[5];
      link_ok_r <= sym_mode ? s2_r[6] : 1'b1;
    end
  end

  // receive path: edge finder needs link clocks well below sys_clk; slow rate only
  reg                    in_frame_r;
  reg [`MSMP_RXM_AW-1:0] wr_ptr_r;
  reg [3:0]              lo_nib_r;
  reg                    half_r;
  wire                   mem_we   = rx_rise & rx_dv_s & half_r & ~sym_mode;

  always @(posedge sys_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      in_frame_r          <= 1'b0;
      wr_ptr_r            <= {`MSMP_RXM_AW{1'b0}};
      lo_nib_r            <= 4'h0;
      half_r              <= 1'b0;
      rx_sym_r            <= 5'h00;
      rx_sym_valid_r      <= 1'b0;
      rx_frame_end_r      <= 1'b0;
      rx_frame_err_r      <= 1'b0;
      rx_frame_err_flag_r <= 1'b0;
      rx_mem_len_r        <= {`MSMP_RXM_AW{1'b0}};
    end else begin
      rx_sym_valid_r <= 1'b0;
      rx_frame_end_r <= 1'b0;
      if (rx_rise) begin
        if (rx_dv_s) begin
          rx_sym_r       <= rxd_s;
          rx_sym_valid_r <= 1'b1;
          in_frame_r     <= 1'b1;
          half_r         <= ~half_r;
          lo_nib_r       <= rxd_s[3:0];
          if (mem_we) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
          end
          if (!in_frame_r) begin
            wr_ptr_r            <= {`MSMP_RXM_AW{1'b0}};
            half_r              <= 1'b1;
            rx_frame_err_flag_r <= s2_r[3];
          end else if (s2_r[3]) begin
            rx_frame_err_flag_r <= 1'b1;
          end
        end else if (in_frame_r) begin
          in_frame_r     <= 1'b0;
          half_r         <= 1'b0;
          rx_frame_end_r <= 1'b1;
          rx_frame_err_r <= rx_frame_err_flag_r;
          rx_mem_len_r   <= wr_ptr_r;
        end
      end
    end
  end

  // nibble pairs low first, as the bytes arrive on the wire
  msmp_rx_mem u_mem (
    .clk       (sys_clk),
    .wr_en     (mem_we),
    .wr_addr   (in_frame_r ? wr_ptr_r : {`MSMP_RXM_AW{1'b0}}),
    .wr_data   ({rxd_s[3:0], lo_nib_r}),
    .rd_addr   (rx_mem_addr),
    .rd_data_r (rx_mem_data)
  );

  // transmit path: launch on falling link edge so the phy samples on rising
  reg tx_take_r;
  assign tx_ready = tx_fall;
  always @(posedge sys_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      tx_data_r <= 4'h0;
      tx_sym4_r <= 1'b0;
      tx_en_r   <= 1'b0;
      tx_take_r <= 1'b0;
    end else if (tx_fall) begin
      if (tx_valid) begin
        tx_data_r <= tx_sym[3:0];
        tx_sym4_r <= tx_sym[4] & sym_mode;
        tx_en_r   <= 1'b1;
        tx_take_r <= tx_last;
      end else begin
        tx_data_r <= 4'h0;
        tx_sym4_r <= 1'b0;
        tx_en_r   <= 1'b0;
        tx_take_r <= 1'b0;
      end
    end
  end

  // management: device owns mdc and frames every transfer
  localparam MG_IDLE = 2'h0;
  localparam MG_PRE  = 2'h1;
  localparam MG_XFER = 2'h2;
  reg [1:0]  mg_state_r;
  reg [3:0]  div_r;
  reg [5:0]  bit_r;
  reg [31:0] sh_r;
  reg        rd_r;
  wire       mdc_fall = (div_r == `MSMP_MDC_HALF - 4'h1) & mdc_r;
  wire       mdc_rise = (div_r == `MSMP_MDC_HALF - 4'h1) & ~mdc_r;
  assign mgmt_busy = (mg_state_r != MG_IDLE);

  always @(posedge sys_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      mg_state_r   <= MG_IDLE;
      div_r        <= 4'h0;
      bit_r        <= 6'h00;
      sh_r         <= 32'h0000_0000;
      rd_r         <= 1'b0;
      mdc_r        <= 1'b0;
      mdio_o_r     <= 1'b0;
      mdio_oe_r    <= 1'b0;
      mgmt_rdata_r <= 16'h0000;
      mgmt_done_r  <= 1'b0;
    end else begin
      mgmt_done_r <= 1'b0;
      if (mg_state_r == MG_IDLE) begin
        div_r <= 4'h0;
        mdc_r <= 1'b0;
      end else begin
        div_r <= (div_r == `MSMP_MDC_HALF - 4'h1) ? 4'h0 : div_r + 4'h1;
        if (div_r == `MSMP_MDC_HALF - 4'h1) begin
          mdc_r <= ~mdc_r;
        end
      end
      case (mg_state_r)
        MG_IDLE: begin
          if (mgmt_start) begin
            mg_state_r <= MG_PRE;
            bit_r      <= `MSMP_MDIO_BITS;
            rd_r       <= mgmt_read;
            sh_r       <= {`MSMP_MDIO_ST, mgmt_read ? `MSMP_OP_READ : `MSMP_OP_WRITE,
                           mgmt_phy, mgmt_reg, `MSMP_MDIO_TA, mgmt_wdata};
            mdio_oe_r  <= 1'b1;
            mdio_o_r   <= 1'b1;
          end
        end
        MG_PRE: begin
          if (mdc_fall) begin
            bit_r <= bit_r - 6'h01;
            if (bit_r == 6'h01) begin
              mg_state_r <= MG_XFER;
              bit_r      <= `MSMP_MDIO_BITS;
              mdio_o_r   <= sh_r[31];
            end
          end
        end
        MG_XFER: begin
          if (mdc_fall) begin
            sh_r     <= {sh_r[30:0], 1'b0};
            mdio_o_r <= sh_r[30];
            bit_r    <= bit_r - 6'h01;
            // release the line at turnaround on reads
            if (rd_r && bit_r <= `MSMP_MDIO_TA_BIT) begin
              mdio_oe_r <= 1'b0;
            end
            if (bit_r == 6'h01) begin
              mg_state_r  <= MG_IDLE;
              mdio_oe_r   <= 1'b0;
              mgmt_done_r <= 1'b1;
            end
          end
          if (mdc_rise && rd_r && bit_r <= `MSMP_MDIO_DAT_BIT) begin
            mgmt_rdata_r <= {mgmt_rdata_r[14:0], s2_r[7]};
          end
        end
        default: mg_state_r <= MG_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: hw/msmp_defs.vh
`ifndef MSMP_DEFS_VH
`define MSMP_DEFS_VH

// port modes
`define MSMP_MODE_MII100   2'h0
`define MSMP_MODE_MII10    2'h1
`define MSMP_MODE_TX100    2'h2
`define MSMP_MODE_FX100    2'h3

// management clock: half period in sys_clk cycles (20 MHz / (2*5) = 2 MHz)
`define MSMP_MDC_HALF      4'h5
// management frame length in bits
`define MSMP_MDIO_BITS     6'h20
// management opcodes
`define MSMP_OP_WRITE      2'h1
`define MSMP_OP_READ       2'h2
// start bits (the preamble ones are driven in MG_PRE)
`define MSMP_MDIO_ST       2'h1
// turnaround bits; release and first data bit, counted as bits left in the frame
`define MSMP_MDIO_TA       2'h2
`define MSMP_MDIO_TA_BIT   6'h13
`define MSMP_MDIO_DAT_BIT  6'h10
// receive frame store depth (address bits) and word width
`define MSMP_RXM_AW        11
`define MSMP_RXM_DW        8

`endif

// file: hw/msmp_rx_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "msmp_defs.vh"

module msmp_rx_mem (
  // clock
  input  wire                     clk,
  // write side
  input  wire                     wr_en,
  input  wire [`MSMP_RXM_AW-1:0]  wr_addr,
  input  wire [`MSMP_RXM_DW-1:0]  wr_data,
  // read side
  input  wire [`MSMP_RXM_AW-1:0]  rd_addr,
  output reg  [`MSMP_RXM_DW-1:0]  rd_data_r
);

  reg [`MSMP_RXM_DW-1:0] mem [0:(1<<`MSMP_RXM_AW)-1];

  // no reset: plain block-ram style storage
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// file: dv/msmp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module msmp_chk (
  // system
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [1:0] mode,
  // pins
  input wire logic       col_in,
  input wire logic       rx_valid_in,
  input wire logic       tx_en_r,
  input wire logic       tx_sym4_r,
  // user and status
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       rx_sym_valid_r,
  input wire logic       col_r,
  input wire logic       link_ok_r,
  input wire logic       mgmt_start,
  input wire logic       mgmt_busy,
  input wire logic       mdc_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_txclk; $changed(tx_en_r) |-> $past(tx_ready); endproperty
  a_txclk: assert property (p_txclk) else $error("tx enable off clock");
  property p_txen; $rose(tx_en_r) |-> $past(tx_valid); endproperty
  a_txen: assert property (p_txen) else $error("tx enable without data");
  property p_sym; !mode[1] |-> !tx_sym4_r; endproperty
  a_sym: assert property (p_sym) else $error("fifth bit in mii mode");
  // link is forced good once the mode has settled past the reset sync
  property p_link; !mode[1] && !$past(mode[1], 4) && $past(rst_n, 4) |-> link_ok_r; endproperty
  a_link: assert property (p_link) else $error("link low in mii mode");
  property p_col; $past(col_in, 2) == $past(col_in, 3) && $past(col_in, 3) == $past(col_in, 4)
    |-> col_r == $past(col_in, 2); endproperty
  a_col: assert property (p_col) else $error("collision not followed");
  property p_rxcap; rx_sym_valid_r
    |-> $past(rx_valid_in, 2) || $past(rx_valid_in, 3) || $past(rx_valid_in, 4); endproperty
  a_rxcap: assert property (p_rxcap) else $error("capture outside frame");
  property p_mdc; $changed(mdc_r) |-> mgmt_busy || $past(mgmt_busy); endproperty
  a_mdc: assert property (p_mdc) else $error("mdc moved while idle");
  property p_start; mgmt_start && !mgmt_busy |-> ##[1:2] mgmt_busy; endproperty
  a_start: assert property (p_start) else $error("transfer not started");
endmodule
bind msmp_port msmp_chk u_chk (.sys_clk, .rst_n, .mode, .col_in, .rx_valid_in, .tx_en_r,
  .tx_sym4_r, .tx_valid, .tx_ready, .rx_sym_valid_r, .col_r, .link_ok_r, .mgmt_start,
  .mgmt_busy, .mdc_r);
`default_nettype wire

// file: dv/msmp_phy.sv
`timescale 1ns/1ps
`default_nettype none
module msmp_phy (
  // link clocks
  output logic           rx_clk,
  output logic           tx_clk,
  // receive pins
  output logic [3:0]     rx_data_in,
  output logic           rx_valid_in,
  output logic           rx_err_in,
  // transmit pins
  input wire logic [3:0] tx_data_r,
  input wire logic       tx_en_r
);
  logic       act;
  logic [3:0] txq [$];
  initial begin
    rx_clk = 0;
    tx_clk = 0;
    rx_data_in = 4'h0;
    rx_valid_in = 0;
    rx_err_in = 0;
    act = 0;
    // link clocks run slow: a fast pair would outrun the sys_clk edge finder
    fork
      forever #200 rx_clk = ~rx_clk;
      #130 forever #200 tx_clk = ~tx_clk;
    join_none
  end
  // idle data keeps toggling so a stale nibble never looks like data
  always @(negedge rx_clk) if (!act) rx_data_in <= ~rx_data_in;
  task send(input int n, input int e);
    act = 1;
    @(negedge rx_clk);
    for (int i = 0; i < n; i++) begin
      rx_data_in <= i[3:0] ^ 4'ha;
      rx_valid_in <= 1'b1;
      rx_err_in <= (i == e);
      @(negedge rx_clk);
    end
    rx_valid_in <= 1'b0;
    rx_err_in <= 1'b0;
    act = 0;
  endtask
  always @(posedge tx_clk) if (tx_en_r) txq.push_back(tx_data_r);
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk, rst_n, rx_clk, tx_clk, rx_valid_in, rx_err_in, crs_in, col_in;
  logic        rx_sym4_in, signal_detect_in, tx_sym4_r, tx_en_r, tx_valid, tx_last, tx_ready;
  logic        rx_frame_err_flag_r, crs_r, col_r, link_ok_r, mgmt_start, mgmt_read;
  logic        mgmt_busy, mgmt_done_r, mdc_r, mdio_o_r, mdio_oe_r, mdio_i;
  logic [1:0]  mode;
  logic [3:0]  rx_data_in, tx_data_r;
  logic        rx_frame_end_r, rx_frame_err_r;
  logic [4:0]  tx_sym, mgmt_phy, mgmt_reg, rx_sym_r;
  logic [7:0]  rx_mem_data;
  logic [10:0] rx_mem_addr, rx_mem_len_r;
  logic [15:0] mgmt_wdata, mgmt_rdata_r;
  int          failures, check_count, frame_ends;
  // pulled-up line when nobody drives it
  assign mdio_i = mdio_oe_r ? mdio_o_r : 1'b1;
  always @(posedge sys_clk) if (rx_frame_end_r === 1'b1) frame_ends <= frame_ends + 1;
  msmp_port u_dut (.sys_clk, .rst_n, .mode, .rx_clk, .rx_data_in, .rx_sym4_in, .rx_valid_in,
    .rx_err_in, .crs_in, .col_in, .signal_detect_in, .tx_clk, .tx_data_r, .tx_sym4_r,
    .tx_en_r, .tx_valid, .tx_sym, .tx_last, .tx_ready, .rx_sym_r, .rx_sym_valid_r(),
    .rx_frame_end_r, .rx_frame_err_r, .rx_frame_err_flag_r, .rx_mem_data, .rx_mem_addr,
    .rx_mem_len_r, .crs_r, .col_r, .link_ok_r, .mgmt_start, .mgmt_read, .mgmt_phy, .mgmt_reg,
    .mgmt_wdata, .mgmt_busy, .mgmt_rdata_r, .mgmt_done_r, .mdc_r, .mdio_o_r, .mdio_oe_r,
    .mdio_i);
  msmp_phy u_phy (.rx_clk, .tx_clk, .rx_data_in, .rx_valid_in, .rx_err_in, .tx_data_r,
    .tx_en_r);
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task t_rx;
    mode = 2'h1;
    rx_sym4_in = 1;
    crs_in = 1;
    u_phy.send(8, 99);
    cyc(20);
    chk(rx_mem_len_r, 4);
    chk(rx_frame_err_flag_r, 0);
    chk(rx_frame_err_r, 0);
    chk(rx_mem_data, 8'hba);
    chk(rx_sym_r, 5'h0d);
    chk(frame_ends, 1);
    chk(link_ok_r, 1);
    u_phy.send(7, 3);
    cyc(20);
    crs_in = 0;
    chk(rx_mem_len_r, 3);
    chk(rx_frame_err_flag_r, 1);
    chk(rx_frame_err_r, 1);
    chk(rx_sym_r, 5'h0c);
    mode = 2'h2;
    u_phy.send(2, 99);
    cyc(20);
    chk(rx_sym_r, 5'h1b);
    chk(rx_mem_len_r, 0);
    chk(frame_ends, 3);
    rx_sym4_in = 0;
    mode = 2'h1;
    $display("rx test done");
  endtask
  task t_tx;
    int k;
    mode = 2'h1;
    for (int i = 0; i < 4; i++) begin
      tx_sym = {1'b1, 4'h3 + i[3:0]};
      tx_last = (i == 3);
      tx_valid = 1;
      k = 0;
      do @(negedge sys_clk); while (tx_ready !== 1'b1 && k++ < 100);
      cyc(1);
    end
    tx_valid = 0;
    cyc(40);
    chk(u_phy.txq.size(), 4);
    chk(tx_en_r, 0);
    for (int i = 0; i < 4; i++) chk(u_phy.txq[i], 4'h3 + i);
    mode = 2'h2;
    tx_sym = 5'h1e;
    tx_valid = 1;
    k = 0;
    do @(negedge sys_clk); while (tx_ready !== 1'b1 && k++ < 100);
    cyc(1);
    tx_valid = 0;
    chk({tx_en_r, tx_sym4_r, tx_data_r}, 6'h3e);
    cyc(20);
    $display("tx test done");
  endtask
  task t_mgmt;
    int  n;
    int  k;
    logic p;
    logic [63:0] fr;
    for (int r = 0; r < 2; r++) begin
      fr = 64'h0;
      mgmt_read = r[0];
      mgmt_start = 1;
      cyc(1);
      mgmt_start = 0;
      n = 0;
      k = 0;
      p = mdc_r;
      while (mgmt_done_r !== 1'b1 && k++ < 2000) begin
        @(negedge sys_clk);
        if (mdc_r && !p) fr = {fr[62:0], mdio_i};
        n += (mdc_r && !p);
        p = mdc_r;
      end
      chk(n, 64);
      chk(fr[63:32], 32'hffff_ffff);
      chk(fr[31:0], r ? 32'h608b_ffff : 32'h508a_5a3c);
      if (r == 1) chk(mgmt_rdata_r, 16'hffff);
      cyc(2);
    end
    $display("mgmt test done");
  endtask
  task t_stat;
    col_in = 1;
    crs_in = 1;
    cyc(6);
    chk({col_r, crs_r}, 2'h3);
    col_in = 0;
    crs_in = 0;
    cyc(6);
    chk({col_r, crs_r}, 2'h0);
    mode = 2'h2;
    for (int s = 0; s < 2; s++) begin
      signal_detect_in = s[0];
      cyc(6);
      chk(link_ok_r, s);
    end
    mode = 2'h3;
    cyc(6);
    chk(link_ok_r, 1);
    signal_detect_in = 0;
    cyc(6);
    chk(link_ok_r, 0);
    $display("status test done");
  endtask
  initial begin
    {rst_n, crs_in, col_in, rx_sym4_in, signal_detect_in, tx_valid, tx_last} = 0;
    {mgmt_start, mgmt_read, mode, tx_sym, rx_mem_addr} = 0;
    mgmt_phy = 5'h01;
    mgmt_reg = 5'h02;
    mgmt_wdata = 16'h5a3c;
    cyc(4);
    rst_n = 1;
    cyc(6);
    t_rx;
    t_tx;
    t_mgmt;
    t_stat;
    test_done;
  end
  initial begin
    #3000000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
